/* core/fpc_ctrl.sv */
// flyback pwm and protection controller with ahb-lite registers
// ==================================================================
`timescale 1ns/10ps
`default_nettype none
module fpc_ctrl
	import fpc_pkg::*;
#(
	parameter int OLP_CYCLES = OLP_CYCLES_DEF
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic [31:0] hrdata,
	output var  logic        hresp,
	// analog comparator decisions and feedback sample
	input  wire fpc_cmp_s    cmp_in,
	input  wire logic [11:0] feedback_level,
	// power stage
	output var  logic        gate_drive,
	output var  logic        hv_source_en,
	output var  logic [11:0] ipk_code,
	// interrupt
	output var  logic        irq
);
	if (OLP_CYCLES < 2 || OLP_CYCLES > 65535) begin : g_bad_olp
		$error("OLP_CYCLES out of range");
	end

	// ==================================================================
	// synchronised comparators
	fpc_cmp_s  c;
	logic [$bits(fpc_cmp_s)-1:0] c_vec;

	fpc_sync #(.W($bits(fpc_cmp_s))) u_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (cmp_in),
		.sync_out (c_vec)
	);
	assign c = fpc_cmp_s'(c_vec);

	// ==================================================================
	// helpers
	function automatic logic [2:0] reg_sel(input logic [7:0] a);
		case (a)
			ADDR_CTRL:     reg_sel = 3'h1;
			ADDR_RSET:     reg_sel = 3'h2;
			ADDR_STATUS:   reg_sel = 3'h3;
			ADDR_IRQ_STAT: reg_sel = 3'h4;
			ADDR_IRQ_MASK: reg_sel = 3'h5;
			ADDR_OLP_CNT:  reg_sel = 3'h6;
			default:       reg_sel = 3'h0;
		endcase
	endfunction : reg_sel

	fpc_regs_s q;
	fpc_regs_s d;

	logic             fault_now;
	logic             cyc_start;
	logic             osc_last;
	logic             gate_kill;
	logic             addr_ok;
	logic [EV_W-1:0]  ev;
	logic [EV_W-1:0]  clr;
	logic [39:0]      prop;
	logic [11:0]      fb_div;
	logic [11:0]      lim;

	// ==================================================================
	// next state
	always_comb begin
		d   = q;
		ev  = '0;
		clr = '0;
		fault_now = q.ovp_f | q.otp | c.prot_pin | q.short_fault | q.overload_fault;
		cyc_start = (q.osc_cnt == 20'h00000);
		osc_last  = (q.osc_cnt >= q.period - 20'h00001);

		// oscillator, period latched at cycle end
		prop = (40'(q.rset) * 40'(PROP_NUM)) / 40'(PROP_DEN);
		d.osc_cnt = osc_last ? 20'h00000 : q.osc_cnt + 20'h00001;
		if (osc_last) d.period = 20'(PERIOD_FIXED_CYC) + prop[19:0];

		// peak threshold: feedback over ratio, clamped, soft-start limited
		fb_div = 12'((24'(feedback_level) * 24'h00000A) / 24'(DIV_RATIO_X10));
		lim    = (fb_div > 12'(ICS_MAX_MV)) ? 12'(ICS_MAX_MV) : fb_div;
		d.ipk  = (lim > q.ss) ? q.ss : lim;
		if (q.st == ST_RUN) begin
			d.ss_tick = q.ss_tick + 8'h01;
			if (q.ss_tick == 8'(SS_STEP_CYC - 1)) begin
				d.ss_tick = 8'h00;
				if (q.ss < 12'(ICS_MAX_MV)) d.ss = q.ss + 12'h001;
			end
		end else begin
			d.ss      = 12'h000;
			d.ss_tick = 8'h00;
		end

		// burst hysteresis
		if (c.burst_low && !q.burst) begin
			d.burst = 1'b1;
			ev[EV_BURST] = 1'b1;
		end else if (c.burst_high) begin
			d.burst = 1'b0;
		end

		// supply over-voltage filter
		if (!c.supply_over) begin
			d.ovp_cnt = 10'h000;
			d.ovp_f   = 1'b0;
		end else if (q.ovp_cnt != 10'(OVP_FILT_CYC)) begin
			d.ovp_cnt = q.ovp_cnt + 10'h001;
		end
		if (d.ovp_cnt == 10'(OVP_FILT_CYC) && !q.ovp_f) begin
			d.ovp_f = 1'b1;
			ev[EV_OVP] = 1'b1;
		end

		// thermal hysteresis
		if (c.temp_hot && !q.otp) begin
			d.otp = 1'b1;
			ev[EV_OTP] = 1'b1;
		end else if (c.temp_cool) begin
			d.otp = 1'b0;
		end

		// overload counted in switching cycles
		if (!c.overload_trip) begin
			d.olp_cnt = '0;
		end else if (cyc_start && q.st == ST_RUN && !q.overload_fault) begin
			d.olp_cnt = q.olp_cnt + 1'b1;
			if (q.olp_cnt == OLP_CNT_W'(OLP_CYCLES - 1)) begin
				d.overload_fault = 1'b1;
				ev[EV_OLP] = 1'b1;
			end
		end

		// gate and edge blanking
		gate_kill = fault_now || q.st != ST_RUN || osc_last || !q.enable;
		if (q.blank1 != 5'h00) d.blank1 = q.blank1 - 5'h01;
		if (q.blank2 != 5'h00) d.blank2 = q.blank2 - 5'h01;
		if (cyc_start && q.st == ST_RUN && q.enable && !q.burst && !fault_now) begin
			d.gate   = 1'b1;
			d.blank1 = 5'(CUR_BLANK_CYC);
			d.blank2 = 5'(SHORT_BLANK_CYC);
		end else if (q.gate) begin
			if (q.blank2 == 5'h00 && c.short_trip) begin
				d.short_fault  = 1'b1;
				d.gate = 1'b0;
				ev[EV_SCP] = 1'b1;
			end else if (q.blank1 == 5'h00 && c.cur_limit) begin
				d.gate = 1'b0;
			end else if (gate_kill) begin
				d.gate = 1'b0;
			end
		end
		if (c.prot_pin && q.st == ST_RUN) ev[EV_PRO] = 1'b1;

		// supply lockout and auto-recovery
		case (q.st)
			ST_CHARGE: begin
				d.hv_en = 1'b1;
				if (c.supply_start) begin
					d.st    = ST_RUN;
					d.hv_en = 1'b0;
				end
			end
			ST_RUN: begin
				d.hv_en = 1'b0;
				if (fault_now || d.short_fault || d.overload_fault || d.ovp_f || d.otp) begin
					d.st   = ST_PDIS;
					d.gate = 1'b0;
				end else if (c.supply_below_stop) begin
					d.st    = ST_CHARGE;
					d.hv_en = 1'b1;
					d.gate  = 1'b0;
					ev[EV_LOCKOUT] = 1'b1;
				end
			end
			ST_PDIS: begin
				d.hv_en = 1'b0;
				if (c.supply_below_recharge) begin
					d.st    = ST_PCHG;
					d.hv_en = 1'b1;
				end
			end
			ST_PCHG: begin
				d.hv_en = 1'b1;
				if (c.supply_start) begin
					d.hv_en = 1'b0;
					d.short_fault   = 1'b0;
					d.overload_fault   = 1'b0;
					// count afresh, so a lasting overload trips again
					d.olp_cnt = '0;
					d.st    = (q.ovp_f || q.otp || c.prot_pin) ? ST_PDIS : ST_RUN;
				end
			end
			default: begin
				d.st    = ST_CHARGE;
				d.hv_en = 1'b1;
			end
		endcase

		// ahb-lite slave: writes zero-wait, reads one wait state
		addr_ok   = hsel && hready && htrans[1];
		d.wr_pend = addr_ok && hwrite;
		d.rd_pend = addr_ok && !hwrite;
		if (addr_ok) d.bus_addr = haddr[7:0];
		d.hready  = !(addr_ok && !hwrite);
		if (q.wr_pend) begin
			case (reg_sel(q.bus_addr))
				3'h1: d.enable   = hwdata[0];
				3'h2: d.rset     = hwdata[15:0];
				3'h4: clr        = hwdata[EV_W-1:0];
				3'h5: d.irq_mask = hwdata[EV_W-1:0];
				default: d.enable = d.enable;
			endcase
		end
		if (q.rd_pend) begin
			case (reg_sel(q.bus_addr))
				3'h1: d.hrdata = {31'h00000000, q.enable};
				3'h2: d.hrdata = {16'h0000, q.rset};
				3'h3: d.hrdata = {20'h00000, q.burst, q.overload_fault, q.short_fault, q.otp, q.ovp_f,
						c.prot_pin, q.hv_en, q.gate, q.st, 2'h0};
				3'h4: d.hrdata = {25'h0000000, q.irq_stat};
				3'h5: d.hrdata = {25'h0000000, q.irq_mask};
				3'h6: d.hrdata = {16'h0000, q.olp_cnt};
				default: d.hrdata = 32'h00000000;
			endcase
		end

		// sticky events: a new event beats a write-one clear
		d.irq_stat = (q.irq_stat & ~clr) | ev;
		d.irq      = |(q.irq_stat & q.irq_mask);
	end

	// ==================================================================
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q        <= '0;
			q.st     <= ST_CHARGE;
			q.hv_en  <= 1'b1;
			q.enable <= 1'b1;
			q.rset   <= RSET_RST[15:0];
			q.period <= 20'(PERIOD_FIXED_CYC + RSET_RST * PROP_NUM / PROP_DEN);
			q.hready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign hreadyout    = q.hready;
	assign hrdata       = q.hrdata;
	assign hresp        = 1'b0;
	assign gate_drive   = q.gate;
	assign hv_source_en = q.hv_en;
	assign ipk_code     = q.ipk;
	assign irq          = q.irq;

	// ==================================================================
	// assertions
	sequence s_gate_on;
		$rose(q.gate);
	endsequence
	sequence s_gate_off;
		$fell(q.gate);
	endsequence

	a_gate_cycle_start: assert property (@(posedge hclk) disable iff (!hresetn)
		s_gate_on |-> $past(q.osc_cnt) == 20'h00000 && $past(q.st) == ST_RUN)
		else $error("gate rose away from cycle start");
	a_cur_blank_held: assert property (@(posedge hclk) disable iff (!hresetn)
		s_gate_off |-> $past(q.blank1) == 5'h00 || $past(gate_kill) || $rose(q.short_fault)
			|| q.st != ST_RUN)
		else $error("current limit cut the pulse inside blanking");
	a_short_blank_held: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(q.short_fault) |-> $past(q.blank2) == 5'h00 && $past(q.gate))
		else $error("short trip taken inside blanking");
	a_start_source_off: assert property (@(posedge hclk) disable iff (!hresetn)
		q.st == ST_RUN |-> !q.hv_en)
		else $error("start-up source on while switching");
	a_lockout_recharge: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(q.st) == ST_RUN && q.st == ST_CHARGE |-> q.hv_en && !q.gate)
		else $error("lockout did not restore start-up source");
	a_fault_low_level: assert property (@(posedge hclk) disable iff (!hresetn)
		q.st == ST_PDIS && !c.supply_below_recharge |=> q.st == ST_PDIS && !q.hv_en)
		else $error("left discharge before recharge level");
	a_peak_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
		q.ipk <= 12'(ICS_MAX_MV))
		else $error("peak threshold above maximum");
	a_soft_start_cap: assert property (@(posedge hclk) disable iff (!hresetn)
		q.st == ST_RUN && $past(q.st) == ST_RUN |-> q.ipk <= q.ss)
		else $error("threshold ahead of soft-start ramp");
	a_overload_count: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(q.overload_fault) |-> $past(q.olp_cnt) == OLP_CNT_W'(OLP_CYCLES - 1))
		else $error("overload tripped at wrong cycle count");
	a_burst_no_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(q.burst) |-> !$rose(q.gate))
		else $error("pulse issued in burst pause");
	a_protect_stop: assert property (@(posedge hclk) disable iff (!hresetn)
		c.prot_pin && q.st == ST_RUN |=> q.st == ST_PDIS ##1 !q.gate)
		else $error("protection pin did not shut down");
	a_thermal_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		q.otp && !c.temp_cool |=> q.otp)
		else $error("thermal fault released before recovery level");
	a_ovp_filter: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(q.ovp_f) |-> q.ovp_cnt == 10'(OVP_FILT_CYC) && $past(c.supply_over))
		else $error("over-voltage taken before filter time");
endmodule : fpc_ctrl
`default_nettype wire

/* core/fpc_pkg.sv */
// package: constants, types and register map of the flyback pwm protection controller
package fpc_pkg;

	// ==================================================================
	// clock and timing
	localparam int CLK_PERIOD_NS   = 50;
	localparam int CUR_BLANK_NS    = 650;
	localparam int SHORT_BLANK_NS  = 600;
	localparam int OVP_FILT_NS     = 20000;
	localparam int SS_TIME_US      = 3000;
	localparam int PERIOD_FIXED_NS = 200;
	localparam int SLOPE_PS_X10    = 1125;
	localparam int VREF_MV         = 1230;
	// least times round up to whole cycles
	localparam int CUR_BLANK_CYC   = (CUR_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHORT_BLANK_CYC = (SHORT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OVP_FILT_CYC    = (OVP_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PERIOD_FIXED_CYC = (PERIOD_FIXED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// period part per kohm of timing resistor, as a ratio of cycles
	localparam int PROP_NUM        = SLOPE_PS_X10 * 100;
	localparam int PROP_DEN        = VREF_MV * CLK_PERIOD_NS;

	// ==================================================================
	// current thresholds in mV
	localparam int ICS_MAX_MV      = 960;
	localparam int DIV_RATIO_X10   = 33;
	localparam int SS_STEP_CYC     = (SS_TIME_US * 1000 / CLK_PERIOD_NS) / ICS_MAX_MV;
	localparam int OLP_CYCLES_DEF  = 8192;
	localparam int OLP_CNT_W       = 16;
	localparam logic [19:0] RSET_RST = 20'h00064;

	// ==================================================================
	// register map, byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_RSET     = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	localparam logic [7:0] ADDR_OLP_CNT  = 8'h14;
	// event bit positions in irq status and mask
	localparam int EV_OVP     = 0;
	localparam int EV_OLP     = 1;
	localparam int EV_SCP     = 2;
	localparam int EV_OTP     = 3;
	localparam int EV_PRO     = 4;
	localparam int EV_BURST   = 5;
	localparam int EV_LOCKOUT = 6;
	localparam int EV_W       = 7;

	// ==================================================================
	// types
	typedef enum logic [1:0] {
		ST_CHARGE = 2'b00,
		ST_RUN    = 2'b01,
		ST_PDIS   = 2'b11,
		ST_PCHG   = 2'b10
	} fpc_state_e;

	typedef struct packed {
		logic supply_start;
		logic supply_below_stop;
		logic supply_below_recharge;
		logic supply_over;
		logic overload_trip;
		logic short_trip;
		logic cur_limit;
		logic burst_low;
		logic burst_high;
		logic temp_hot;
		logic temp_cool;
		logic prot_pin;
	} fpc_cmp_s;

	typedef struct packed {
		fpc_state_e       st;
		logic             enable;
		logic [15:0]      rset;
		logic [EV_W-1:0]  irq_stat;
		logic [EV_W-1:0]  irq_mask;
		logic [19:0]      osc_cnt;
		logic [19:0]      period;
		logic             gate;
		logic             hv_en;
		logic [11:0]      ipk;
		logic [11:0]      ss;
		logic [7:0]       ss_tick;
		logic [4:0]       blank1;
		logic [4:0]       blank2;
		logic             burst;
		logic [9:0]       ovp_cnt;
		logic             ovp_f;
		logic             otp;
		logic [OLP_CNT_W-1:0] olp_cnt;
		logic             overload_fault;
		logic             short_fault;
		logic             wr_pend;
		logic             rd_pend;
		logic [7:0]       bus_addr;
		logic [31:0]      hrdata;
		logic             hready;
		logic             irq;
	} fpc_regs_s;

endpackage : fpc_pkg

/* core/fpc_sync.sv */
// three-flop synchroniser, output moves once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module fpc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// levels
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	// ==================================================================
	// state
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] o;
	} fpc_sync_s;

	fpc_sync_s q;
	fpc_sync_s d;

	if (W < 1) begin : g_bad_width
		$error("fpc_sync width must be positive");
	end

	// stage one is seen only by stage two
	always_comb begin
		d    = q;
		d.s1 = async_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i]) d.o[i] = q.s3[i];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) q <= '0;
		else q <= d;
	end

	assign sync_out = q.o;
endmodule : fpc_sync
`default_nettype wire

/* testbench/flyback_pwm_protection_control_tb_top.sv */
// testbench: registers, pwm timing, burst and protection recovery of the controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
`define WAIT(c, lim) begin int n_; n_ = 0; while (!(c) && n_ < lim) begin @(posedge hclk); n_++; end end
module flyback_pwm_protection_control_tb_top
	import fpc_pkg::*;
;
	typedef struct {logic [7:0] a; logic wr; logic [31:0] wd; logic [31:0] ex;} fpc_row_s;
	localparam int CYC_LIMIT = 100000;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
	logic [1:0] htrans = 2'h0;
	logic [15:0] supply_mv = 16'h0, fb_mv = 16'h07D0, temp_c = 16'h0019, pro_mv = 16'h0;
	logic [15:0] cs_slope = 16'h0014, cs_spike = 16'h0;
	wire logic hreadyout, hresp, gate_drive, hv_source_en, irq;
	wire logic [31:0] hrdata;
	wire logic [11:0] ipk_code, feedback_level;
	wire fpc_cmp_s cmp_in;
	int fails = 0, total_checks = 0, cycles = 0, w;
	int flag_bit [5] = '{7, 10, 9, 8, 6};
	fpc_row_s rows [9] = '{'{ADDR_CTRL, 1'b0, 32'h0, 32'h1}, '{ADDR_RSET, 1'b0, 32'h0, 32'h64},
		'{ADDR_STATUS, 1'b0, 32'h0, 32'h20}, '{ADDR_IRQ_STAT, 1'b0, 32'h0, 32'h0},
		'{ADDR_OLP_CNT, 1'b0, 32'h0, 32'h0}, '{8'h18, 1'b1, 32'hFFFFFFFF, 32'h0},
		'{ADDR_RSET, 1'b1, 32'hC8, 32'hC8}, '{ADDR_RSET, 1'b1, 32'h64, 32'h64},
		'{ADDR_STATUS, 1'b1, 32'hFFFF, 32'h20}};

	// small overload count keeps the run short
	fpc_ctrl #(.OLP_CYCLES(8)) fpc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.cmp_in(cmp_in), .feedback_level(feedback_level), .gate_drive(gate_drive),
		.hv_source_en(hv_source_en), .ipk_code(ipk_code), .irq(irq));
	fpc_plant_model fpc_plant_model_inst (.hclk(hclk), .gate_drive(gate_drive),
		.ipk_code(ipk_code), .supply_mv(supply_mv), .fb_mv(fb_mv), .temp_c(temp_c),
		.pro_mv(pro_mv), .cs_slope(cs_slope), .cs_spike(cs_spike), .cmp_in(cmp_in),
		.feedback_level(feedback_level));

	always #25 hclk = ~hclk;
	always @(posedge hclk) begin
		cycles++;
		if (cycles == CYC_LIMIT) begin
			fails++;
			$display("timeout after %0d cycles", cycles);
			end_of_test();
		end
	end

	// ==================================================================
	// bus and timing helpers
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
		hsel <= 1'b0;
	endtask : bus
	task automatic wait_state(input logic [1:0] s, input int lim);
		int n;
		n = 0;
		bus(ADDR_STATUS, 1'b0, 32'h0);
		while (q[3:2] !== s && n < lim) begin
			bus(ADDR_STATUS, 1'b0, 32'h0);
			n++;
		end
		`CHK("state", s, q[3:2])
	endtask : wait_state
	task automatic quiet(input int n);
		int h;
		h = 0;
		repeat (n) begin
			@(posedge hclk);
			if (gate_drive !== 1'b0) h++;
		end
		`CHK("gate_quiet", 0, h)
	endtask : quiet
	task automatic pulse_width();
		`WAIT(gate_drive === 1'b0, 400)
		`WAIT(gate_drive === 1'b1, 400)
		w = 0;
		while (gate_drive === 1'b1 && w < 400) begin
			@(posedge hclk);
			w++;
		end
	endtask : pulse_width
	task automatic period();
		pulse_width();
		while (gate_drive !== 1'b1 && w < 3000) begin
			@(posedge hclk);
			w++;
		end
	endtask : period
	task automatic set_fault(input int k, input logic on);
		case (k)
			0: if (on) supply_mv <= 16'h61A8;
			1: fb_mv <= on ? 16'h0F3C : 16'h0672;
			2: cs_spike <= on ? 16'h05DC : 16'h0000;
			3: temp_c <= on ? 16'h00A0 : 16'h0064;
			default: pro_mv <= on ? 16'h0DAC : 16'h0000;
		endcase
	endtask : set_fault
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	// ==================================================================
	// main sequence
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			if (rows[i].wr) bus(rows[i].a, 1'b1, rows[i].wd);
			bus(rows[i].a, 1'b0, 32'h0);
			`CHK("reg", rows[i].ex, q)
		end
		$display("test registers done");
		fb_mv <= 16'h0672;
		supply_mv <= 16'h2EE0;
		wait_state(2'b01, 50);
		`CHK("hv_off", 1'b0, hv_source_en)
		`CHK("ss_start", 1'b1, ipk_code < 12'h064)
		period();
		`CHK("period_100k", PERIOD_FIXED_CYC + 100 * PROP_NUM / PROP_DEN, w)
		bus(ADDR_RSET, 1'b1, 32'h32);
		period();
		period();
		`CHK("period_50k", PERIOD_FIXED_CYC + 50 * PROP_NUM / PROP_DEN, w)
		bus(ADDR_RSET, 1'b1, 32'h64);
		cs_spike <= 16'h03E8;
		pulse_width();
		`CHK("blank", 1'b1, w >= CUR_BLANK_CYC && w <= CUR_BLANK_CYC + 6)
		cs_spike <= 16'h0000;
		`WAIT(ipk_code === 12'h1F4, 40000)
		`CHK("ipk_fb", 12'h1F4, ipk_code)
		pulse_width();
		// sense reaches 500 mV after 25 cycles at 20 mV a cycle
		`CHK("on_time", 1'b1, w >= 25 && w <= 31)
		fb_mv <= 16'h0DAC;
		`WAIT(ipk_code === 12'h3C0, 40000)
		`CHK("ipk_clamp", 12'h3C0, ipk_code)
		$display("test pwm done");
		bus(ADDR_IRQ_STAT, 1'b1, 32'h7F);
		bus(ADDR_IRQ_MASK, 1'b1, 32'h1 << EV_BURST);
		fb_mv <= 16'h0190;
		`WAIT(irq === 1'b1, 400)
		`CHK("irq_burst", 1'b1, irq)
		`WAIT(gate_drive === 1'b0, 400)
		quiet(400);
		fb_mv <= 16'h0258;
		quiet(400);
		fb_mv <= 16'h0320;
		`WAIT(gate_drive === 1'b1, 400)
		`CHK("burst_exit", 1'b1, gate_drive)
		bus(ADDR_IRQ_STAT, 1'b1, 32'h1 << EV_BURST);
		`WAIT(irq === 1'b0, 10)
		`CHK("irq_clear", 1'b0, irq)
		bus(ADDR_CTRL, 1'b1, 32'h0);
		`WAIT(gate_drive === 1'b0, 400)
		quiet(400);
		bus(ADDR_CTRL, 1'b1, 32'h1);
		`WAIT(gate_drive === 1'b1, 400)
		`CHK("enable_on", 1'b1, gate_drive)
		$display("test burst done");
		for (int k = 0; k < 5; k++) begin
			set_fault(k, 1'b1);
			wait_state(2'b11, 1000);
			`CHK("fault_flag", 1'b1, q[flag_bit[k]])
			quiet(200);
			supply_mv <= 16'h1964;
			quiet(100);
			wait_state(2'b11, 1);
			`CHK("hv_pdis", 1'b0, hv_source_en)
			supply_mv <= 16'h1388;
			wait_state(2'b10, 100);
			`CHK("hv_pchg", 1'b1, hv_source_en)
			set_fault(k, 1'b0);
			quiet(10);
			supply_mv <= 16'h2EE0;
			wait_state(2'b01, 200);
			`WAIT(gate_drive === 1'b1, 400)
			`CHK("resume", 1'b1, gate_drive)
			$display("test fault %0d done", k);
		end
		supply_mv <= 16'h1B58;
		wait_state(2'b00, 100);
		`CHK("hv_on", 1'b1, hv_source_en)
		quiet(200);
		$display("test lockout done");
		bus(ADDR_IRQ_STAT, 1'b0, 32'h0);
		`CHK("irq_events", 32'h5F, q)
		bus(ADDR_IRQ_MASK, 1'b1, 32'h7F);
		`WAIT(irq === 1'b1, 10)
		`CHK("irq_fault", 1'b1, irq)
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		`CHK("rst_pins", 5'h0C, {gate_drive, hv_source_en, hreadyout, irq, hresp})
		`CHK("rst_data", 44'h0, {ipk_code, hrdata})
		hresetn <= 1'b1;
		bus(ADDR_IRQ_STAT, 1'b0, 32'h0);
		`CHK("irq_rst", 32'h0, q)
		bus(ADDR_IRQ_MASK, 1'b0, 32'h0);
		`CHK("mask_rst", 32'h0, q)
		$display("test reset done");
		end_of_test();
	end
endmodule : flyback_pwm_protection_control_tb_top
`default_nettype wire

/* testbench/fpc_plant_model.sv */
// partner model: supply, feedback, sense and thermal comparators around the controller
`timescale 1ns/10ps
`default_nettype none
module fpc_plant_model
	import fpc_pkg::*;
#(
	parameter int START_MV = 11700,
	parameter int STOP_MV  = 8000,
	parameter int RECHG_MV = 5300,
	parameter int OVER_MV  = 24000,
	parameter int OLOAD_MV = 3800,
	parameter int SHORT_MV = 1420,
	parameter int BLO_MV   = 500,
	parameter int BHI_MV   = 700,
	parameter int HOT_C    = 150,
	parameter int COOL_C   = 120,
	parameter int PRO_MV   = 3100
) (
	// clock
	input  wire logic        hclk,
	// power stage from the controller
	input  wire logic        gate_drive,
	input  wire logic [11:0] ipk_code,
	// analog conditions set by the bench
	input  wire logic [15:0] supply_mv,
	input  wire logic [15:0] fb_mv,
	input  wire logic [15:0] temp_c,
	input  wire logic [15:0] pro_mv,
	input  wire logic [15:0] cs_slope,
	input  wire logic [15:0] cs_spike,
	// comparator decisions to the controller
	output var  fpc_cmp_s    cmp_in,
	output var  logic [11:0] feedback_level
);
	// ==================================================================
	// sense ramp
	logic [15:0] on_cnt = 16'h0000;
	logic [31:0] cs_mv;
	// the spike models the turn-on edge that blanking must hide
	assign cs_mv = gate_drive ? on_cnt * cs_slope + cs_spike : 32'h00000000;
	// ==================================================================
	// comparators, changed just after the edge like real slow levels
	always @(posedge hclk) begin
		on_cnt <= gate_drive ? on_cnt + 16'h0001 : 16'h0000;
		cmp_in.supply_start <= supply_mv >= START_MV;
		cmp_in.supply_below_stop <= supply_mv < STOP_MV;
		cmp_in.supply_below_recharge <= supply_mv < RECHG_MV;
		cmp_in.supply_over <= supply_mv > OVER_MV;
		cmp_in.overload_trip <= fb_mv >= OLOAD_MV;
		cmp_in.short_trip <= cs_mv > SHORT_MV;
		cmp_in.cur_limit <= cs_mv >= ipk_code;
		cmp_in.burst_low <= fb_mv < BLO_MV;
		cmp_in.burst_high <= fb_mv > BHI_MV;
		cmp_in.temp_hot <= temp_c > HOT_C;
		cmp_in.temp_cool <= temp_c < COOL_C;
		cmp_in.prot_pin <= pro_mv > PRO_MV;
		feedback_level <= fb_mv[11:0];
	end
endmodule : fpc_plant_model
`default_nettype wire
